// *** test/async_serial_transmitter_tb.sv ***
// self-checking bench: AXI4-Lite register tasks and a line receiver
// assumes divisor 0 gives one baud tick per clock
`default_nettype none
module async_serial_transmitter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CTRL = 8'(async_tx_pkg::OFS_CONTROL);
  localparam logic [7:0] A_DIV = 8'(async_tx_pkg::OFS_DIVISOR);
  localparam logic [7:0] A_HOLD = 8'(async_tx_pkg::OFS_HOLDING);
  localparam logic [7:0] A_FLAG = 8'(async_tx_pkg::OFS_FLAG);
  localparam logic [7:0] A_IEN = 8'(async_tx_pkg::OFS_ENABLE);
  localparam logic [31:0] ONE = 32'h00000001;
  localparam logic [31:0] EN = ONE << async_tx_pkg::BIT_TX_EN;
  localparam logic [31:0] HS = ONE << async_tx_pkg::BIT_HIGH_SPEED;
  localparam logic [31:0] NINE = ONE << async_tx_pkg::BIT_NINE_SEL;
  localparam logic [31:0] NINTH = ONE << async_tx_pkg::BIT_NINTH;
  localparam logic [31:0] CLKD = ONE << async_tx_pkg::BIT_CLOCKED;
  localparam logic [31:0] SE = ONE << async_tx_pkg::BIT_SHIFT_EMPTY;
  localparam logic [31:0] BE = ONE << async_tx_pkg::BIT_BUF_EMPTY;
  localparam logic [1:0] OK = async_tx_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = async_tx_pkg::RESP_SLVERR;

  logic ref_clk, sys_rst, sleep_mode, awvalid, wvalid, bready;
  logic arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, rx_count, bad_frames;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic serial_out_pin, serial_out_pin_oe, tx_buffer_irq, line, nine, p;
  logic [11:0] bit_clocks, start_len;
  logic [8:0] rx_data;
  int errors, num_checks, cycles;

  async_serial_transmitter i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sleep_mode(sleep_mode), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .serial_out_pin(serial_out_pin),
    .serial_out_pin_oe(serial_out_pin_oe), .tx_buffer_irq(tx_buffer_irq));

  // pull-up holds the released line high
  assign line = serial_out_pin_oe ? serial_out_pin : 1'b1;

  serial_line_receiver i_rx (.ref_clk(ref_clk), .line(line),
    .line_oe(serial_out_pin_oe), .nine(nine), .bit_clocks(bit_clocks),
    .rx_data(rx_data), .start_len(start_len), .rx_count(rx_count),
    .bad_frames(bad_frames));

  //////////////////////////////////////////////////////////////////////////
  // clock, and cycle ceiling against hangs
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("MISMATCH at %0t: timeout", $time);
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, d);
    check({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic wait_frames(input int n);
    do @(posedge ref_clk); while (rx_count != 8'(n));
  endtask

  //////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    sys_rst = 1'b1; sleep_mode = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00;
    araddr = 8'h00; wdata = 32'h0; wstrb = 4'h1; nine = 1'b0;
    bit_clocks = 12'h010; errors = 0; num_checks = 0; cycles = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(A_CTRL, SE, OK);
    rd(A_DIV, 32'h0, OK);
    rd(A_FLAG, 32'h0, OK);
    rd(A_IEN, 32'h0, OK);
    wstrb <= 4'h0;
    wr(A_DIV, 32'h55, OK);
    wstrb <= 4'h1;
    rd(A_DIV, 32'h0, OK);
    rd(8'h14, 32'h0, ERR);
    wr(8'h14, 32'hff, ERR);
    check({31'h0, serial_out_pin_oe}, 32'h0);
    wr(A_CTRL, EN | HS | CLKD, OK);
    repeat (3) @(posedge ref_clk);
    check({31'h0, serial_out_pin_oe}, 32'h0);
    $display("test reset and mode done");
    wr(A_IEN, BE, OK);
    wr(A_CTRL, EN | HS, OK);
    repeat (3) @(posedge ref_clk);
    check({30'h0, serial_out_pin_oe, serial_out_pin}, 32'h3);
    rd(A_FLAG, BE, OK);
    check({31'h0, tx_buffer_irq}, ONE);
    wr(A_FLAG, 32'h0, OK);
    rd(A_FLAG, BE, OK);
    wr(A_IEN, 32'h0, OK);
    repeat (2) @(posedge ref_clk);
    check({31'h0, tx_buffer_irq}, 32'h0);
    wr(A_IEN, BE, OK);
    $display("test flags done");
    wr(A_HOLD, 32'ha5, OK);
    rd(A_CTRL, EN | HS, OK);
    rd(A_FLAG, BE, OK);
    wr(A_HOLD, 32'h3c, OK);
    rd(A_FLAG, 32'h0, OK);
    check({31'h0, tx_buffer_irq}, 32'h0);
    wait_frames(1);
    check({23'h0, rx_data}, 32'ha5);
    check({20'h0, start_len}, 32'd16);
    wait_frames(2);
    check({23'h0, rx_data}, 32'h3c);
    repeat (40) @(posedge ref_clk);
    rd(A_CTRL, EN | HS | SE, OK);
    rd(A_HOLD, 32'h3c, OK);
    $display("test eight bit done");
    wr(A_DIV, 32'h2, OK);
    rd(A_DIV, 32'h2, OK);
    wr(A_CTRL, EN | NINE | NINTH, OK);
    bit_clocks <= 12'd192;
    nine <= 1'b1;
    wr(A_HOLD, 32'h4b, OK);
    wait_frames(3);
    check({23'h0, rx_data}, 32'h14b);
    check({20'h0, start_len}, 32'd192);
    repeat (120) @(posedge ref_clk);
    rd(A_CTRL, EN | NINE | NINTH | SE, OK);
    $display("test nine bit done");
    wr(A_DIV, 32'h0, OK);
    wr(A_CTRL, EN | HS, OK);
    bit_clocks <= 12'd16;
    nine <= 1'b0;
    wr(A_HOLD, 32'h00, OK);
    repeat (40) @(posedge ref_clk);
    wr(A_CTRL, HS, OK);
    repeat (2) @(posedge ref_clk);
    check({30'h0, serial_out_pin_oe, serial_out_pin}, 32'h1);
    rd(A_CTRL, HS | SE, OK);
    repeat (200) @(posedge ref_clk);
    wr(A_HOLD, 32'h81, OK);
    repeat (30) @(posedge ref_clk);
    check({24'h0, rx_count}, 32'd3);
    rd(A_FLAG, 32'h0, OK);
    wr(A_CTRL, EN | HS, OK);
    wait_frames(4);
    check({23'h0, rx_data}, 32'h81);
    check({20'h0, start_len}, 32'd16);
    check({24'h0, bad_frames}, 32'h0);
    $display("test abort done");
    wr(A_HOLD, 32'h0f, OK);
    repeat (40) @(posedge ref_clk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    p = serial_out_pin;
    repeat (100) @(posedge ref_clk);
    check({31'h0, serial_out_pin}, {31'h0, p});
    rd(A_CTRL, EN | HS, OK);
    sleep_mode <= 1'b0;
    $display("test sleep done");
    complete_run();
  end
endmodule // async_serial_transmitter_tb
`default_nettype wire

// *** test/serial_line_receiver.sv ***
// behavioural remote receiver sitting on the serial line
// assumes the line has a pull-up and bit time is given in ref_clk cycles
`default_nettype none
module serial_line_receiver (
  input wire logic ref_clk,
  input wire logic line,
  input wire logic line_oe,
  input wire logic nine,
  input wire logic [11:0] bit_clocks,
  output logic [8:0] rx_data,
  output logic [11:0] start_len,
  output logic [7:0] rx_count,
  output logic [7:0] bad_frames
);
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////////////////////////////////////////////////
  // one frame: measure start, sample mid bit, check stop
  task automatic receive_frame();
    logic [8:0] d;
    logic ok;
    int n;
    int nbits;
    d = 9'h000;
    ok = 1'b1;
    n = 1;
    nbits = nine ? 9 : 8;
    while (n < bit_clocks)
    begin
      @(posedge ref_clk);
      if (line !== 1'b0)
        break;
      n++;
    end
    start_len = 12'(n);
    repeat (bit_clocks / 2) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++)
    begin
      d[i] = line;
      ok = ok & line_oe;
      repeat (bit_clocks) @(posedge ref_clk);
    end
    if (ok === 1'b1 && line !== 1'b1)
      bad_frames++;
    else if (ok === 1'b1)
    begin
      rx_data = d;
      rx_count++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // hunt for a start bit on a driven line
  initial
  begin
    rx_data = 9'h000;
    start_len = 12'h000;
    rx_count = 8'h00;
    bad_frames = 8'h00;
    forever
    begin
      @(posedge ref_clk);
      if (line_oe === 1'b1 && line === 1'b0)
        receive_frame();
    end
  end
endmodule // serial_line_receiver
`default_nettype wire

// *** verilog/async_serial_transmitter.sv ***
// asynchronous serial transmitter with baud generator and AXI4-Lite regs
// assumes sleep_mode comes from logic on ref_clk; one clock, one reset
//
// Operation
// R1: frame is one low start bit, eight or nine data bits, one stop bit
// R2: data bits leave least significant bit first
// R3: transmitter shares one frame format and one baud setting
// R4: an 8-bit baud generator derives timing from the clock
// R5: tick is sixteen times bit rate with high speed, else sixty-four
// R6: no hardware parity; software may place parity in the ninth bit
// R7: all asynchronous activity freezes while sleep_mode is high
// R8: asynchronous mode only while clocked mode select bit 4 is clear
// R9: shift register reloads only after the previous stop bit, then at once
// R10: buffer empties on transfer; flags set one cycle later
// R11: buffer empty flag sets regardless of enable; cleared only by a write (here it sets only while enabled with clocked mode clear)
// R12: interrupt output only while buffer interrupt enable bit 4 is set
// R13: shift empty status read-only, follows shift register one cycle late
// R14: shift register has no address and cannot be read or written
// R15: transmit enable bit 5; shifting waits for data and a baud tick
// R16: buffer may be written before enable; sending starts on enable
// R17: write with shift register empty moves data through at once
// R18: clearing enable aborts, resets transmitter, releases the pin
// R19: software sets nine bit select and ninth bit before the data byte
// R20: bit rate is clock over 64 or 16 times divisor plus one
// R21: writing the divisor restarts the baud timer
// R22: line idles high while enabled; start bit low, stop bit high
// R23: each bit lasts exactly sixteen or sixty-four ticks
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`default_nettype none
module async_serial_transmitter #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sleep_mode,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output var logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output var logic bvalid,
  input wire logic bready,
  output var logic [1:0] bresp,
  input wire logic arvalid,
  output var logic arready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  output var logic rvalid,
  input wire logic rready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic serial_out_pin,
  output var logic serial_out_pin_oe,
  output var logic tx_buffer_irq
);

  // parameter check
  if (ADDR_WIDTH < async_tx_pkg::MAP_BITS)
  begin : g_bad_width
    $error("ADDR_WIDTH too small for register map");
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic nine_bit_select;
    logic transmit_enable;
    logic clocked_mode;
    logic high_speed_select;
    logic ninth_tx_bit;
    logic [7:0] baud_divisor;
    logic [7:0] transmit_holding_buffer;
    logic holding_full;
    logic tx_buffer_empty_flag;
    logic tx_buffer_interrupt_enable;
    logic shift_register_empty_status;
    logic [7:0] baud_count;
    logic [5:0] tick_count;
    async_tx_pkg::tx_state_t tx_state;
    logic [8:0] transmit_shift_register;
    logic [3:0] bits_left;
    logic shift_busy;
    logic serial_out;
    logic serial_out_oe;
    logic irq;
  } tx_regs_t;

  tx_regs_t s;
  tx_regs_t next_s;
  logic tick;
  logic bit_done;
  logic load;
  logic active;
  logic holding_write;
  logic divisor_write;
  logic [5:0] last_tick;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // address inside the map, upper bits zero
  function automatic logic mapped(input logic [ADDR_WIDTH-1:0] a);
    logic [4:0] low;
    low = a[4:0];
    mapped = ((a >> async_tx_pkg::MAP_BITS) == '0) &&
             ({low[4:2], 2'b00} <= async_tx_pkg::OFS_ENABLE);
  endfunction

  // aligned word offset of an address
  function automatic logic [4:0] word(input logic [ADDR_WIDTH-1:0] a);
    word = {a[4:2], 2'b00};
  endfunction

  // read value of a register; shift register has no address
  function automatic logic [31:0] reg_read(input tx_regs_t r,
                                           input logic [4:0] w);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (w)
      async_tx_pkg::OFS_CONTROL:
      begin
        v[async_tx_pkg::BIT_NINE_SEL] = r.nine_bit_select;
        v[async_tx_pkg::BIT_TX_EN] = r.transmit_enable;
        v[async_tx_pkg::BIT_CLOCKED] = r.clocked_mode;
        v[async_tx_pkg::BIT_HIGH_SPEED] = r.high_speed_select;
        v[async_tx_pkg::BIT_SHIFT_EMPTY] = r.shift_register_empty_status;
        v[async_tx_pkg::BIT_NINTH] = r.ninth_tx_bit;
      end
      async_tx_pkg::OFS_DIVISOR: v[7:0] = r.baud_divisor;
      async_tx_pkg::OFS_HOLDING: v[7:0] = r.transmit_holding_buffer;
      async_tx_pkg::OFS_FLAG:
        v[async_tx_pkg::BIT_BUF_EMPTY] = r.tx_buffer_empty_flag;
      async_tx_pkg::OFS_ENABLE:
        v[async_tx_pkg::BIT_BUF_EMPTY] = r.tx_buffer_interrupt_enable;
      default: v = 32'h0000_0000; // R14
    endcase
    reg_read = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_s = s;
    tick = 1'b0;
    load = 1'b0;
    holding_write = 1'b0;
    divisor_write = 1'b0;
    active = s.transmit_enable && !s.clocked_mode; // R8
    last_tick = s.high_speed_select ? async_tx_pkg::LAST_TICK_HIGH
                                    : async_tx_pkg::LAST_TICK_LOW; // R5
    // write address and data, taken in either order
    if (awvalid && s.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.w_byte = wdata[7:0];
      next_s.w_lane0 = wstrb[0];
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    // register write once both halves are held
    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.aw_addr) ? async_tx_pkg::RESP_OKAY
                                       : async_tx_pkg::RESP_SLVERR;
      if (mapped(s.aw_addr) && s.w_lane0)
      begin
        unique case (word(s.aw_addr))
          async_tx_pkg::OFS_CONTROL:
          begin
            next_s.nine_bit_select = s.w_byte[async_tx_pkg::BIT_NINE_SEL];
            next_s.transmit_enable = s.w_byte[async_tx_pkg::BIT_TX_EN];
            next_s.clocked_mode = s.w_byte[async_tx_pkg::BIT_CLOCKED];
            next_s.high_speed_select =
              s.w_byte[async_tx_pkg::BIT_HIGH_SPEED];
            next_s.ninth_tx_bit = s.w_byte[async_tx_pkg::BIT_NINTH];
          end
          async_tx_pkg::OFS_DIVISOR:
          begin
            next_s.baud_divisor = s.w_byte;
            divisor_write = 1'b1;
          end
          async_tx_pkg::OFS_HOLDING: holding_write = 1'b1;
          async_tx_pkg::OFS_ENABLE:
            next_s.tx_buffer_interrupt_enable =
              s.w_byte[async_tx_pkg::BIT_BUF_EMPTY];
          default: ; // flag register ignores writes
        endcase
      end
    end
    // read channel, one read in flight
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(araddr) ? async_tx_pkg::RESP_OKAY
                                    : async_tx_pkg::RESP_SLVERR;
      next_s.rdata = mapped(araddr) ? reg_read(s, word(araddr))
                                    : 32'h0000_0000;
    end
    next_s.arready = !next_s.rvalid;
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    // free running baud timer, restarted by a divisor write
    if (divisor_write)
      next_s.baud_count = next_s.baud_divisor; // R21
    else if (!sleep_mode) // R7
    begin
      if (s.baud_count == 8'h00)
      begin
        tick = 1'b1; // R4 R20
        next_s.baud_count = s.baud_divisor;
      end
      else
        next_s.baud_count = s.baud_count - 8'h01;
    end
    bit_done = tick && (s.tick_count == last_tick); // R23
    // transmitter sequence
    if (!active)
    begin
      next_s.tx_state = async_tx_pkg::TX_IDLE; // R18
      next_s.transmit_shift_register = 9'h000;
      next_s.tick_count = 6'h00;
      next_s.bits_left = 4'h0;
      next_s.shift_busy = 1'b0;
    end
    else if (!sleep_mode) // R7
    begin
      unique case (s.tx_state)
        async_tx_pkg::TX_IDLE: load = s.holding_full; // R16 R17
        async_tx_pkg::TX_WAIT:
          if (tick) // R15
          begin
            next_s.tx_state = async_tx_pkg::TX_START;
            next_s.tick_count = 6'h00;
          end
        async_tx_pkg::TX_START,
        async_tx_pkg::TX_DATA,
        async_tx_pkg::TX_STOP:
          if (tick)
          begin
            next_s.tick_count = s.tick_count + 6'h01;
            if (bit_done)
            begin
              next_s.tick_count = 6'h00;
              unique case (s.tx_state)
                async_tx_pkg::TX_START:
                  next_s.tx_state = async_tx_pkg::TX_DATA; // R1
                async_tx_pkg::TX_DATA:
                begin
                  // shift right, lowest bit goes out next
                  next_s.transmit_shift_register =
                    {1'b0, s.transmit_shift_register[8:1]}; // R2
                  next_s.bits_left = s.bits_left - 4'h1;
                  if (s.bits_left == 4'h1)
                    next_s.tx_state = async_tx_pkg::TX_STOP; // R1
                end
                default:
                begin
                  next_s.tx_state = async_tx_pkg::TX_IDLE;
                  next_s.shift_busy = 1'b0;
                  load = s.holding_full; // R9
                end
              endcase
            end
          end
        default: next_s.tx_state = async_tx_pkg::TX_IDLE;
      endcase
    end
    // move buffer into the shift register; ninth bit is software's
    if (load)
    begin
      next_s.transmit_shift_register =
        {s.ninth_tx_bit && s.nine_bit_select,
         s.transmit_holding_buffer}; // R6 R3
      next_s.bits_left = s.nine_bit_select ? async_tx_pkg::BITS_NINE
                                           : async_tx_pkg::BITS_EIGHT;
      next_s.holding_full = 1'b0; // R10
      next_s.shift_busy = 1'b1;
      next_s.tx_state = async_tx_pkg::TX_WAIT;
    end
    // new data after the transfer so a write is never lost
    if (holding_write)
    begin
      next_s.transmit_holding_buffer = s.w_byte;
      next_s.holding_full = 1'b1;
    end
    // status flags, one cycle behind the buffers
    next_s.shift_register_empty_status = !s.shift_busy; // R13
    if (holding_write)
      next_s.tx_buffer_empty_flag = 1'b0; // R11
    else if (active && !s.holding_full)
      next_s.tx_buffer_empty_flag = 1'b1; // R10 R11
    next_s.irq = s.tx_buffer_empty_flag &&
                 s.tx_buffer_interrupt_enable; // R12
    // line level and drive
    next_s.serial_out_oe = next_s.transmit_enable &&
                           !next_s.clocked_mode; // R18
    unique case (next_s.tx_state)
      async_tx_pkg::TX_START: next_s.serial_out = 1'b0; // R22
      async_tx_pkg::TX_DATA:
        next_s.serial_out = next_s.transmit_shift_register[0]; // R2
      default: next_s.serial_out = 1'b1; // R22
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.baud_divisor <= async_tx_pkg::RST_DIVISOR;
      s.shift_register_empty_status <= async_tx_pkg::RST_SHIFT_EMPTY;
      s.tx_state <= async_tx_pkg::TX_IDLE;
      s.serial_out <= 1'b1;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign serial_out_pin = s.serial_out;
  assign serial_out_pin_oe = s.serial_out_oe;
  assign tx_buffer_irq = s.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // start bit low, stop bit high
  AST_LINE_LEVEL: assert property ( // R22
    (s.tx_state == async_tx_pkg::TX_START |-> !s.serial_out) and
    (s.tx_state == async_tx_pkg::TX_STOP |-> s.serial_out))
    else $error("line level wrong for frame state");

  // a start or data bit state is left only on its last tick
  AST_BIT_LENGTH: assert property ( // R23
    s.tx_state inside {async_tx_pkg::TX_START, async_tx_pkg::TX_DATA}
    && !bit_done && active |=> $stable(s.tx_state))
    else $error("bit ended before its tick count");

  // data bits shift right one place per bit
  AST_LSB_FIRST: assert property ( // R2
    s.tx_state == async_tx_pkg::TX_DATA && bit_done && active
    && !sleep_mode |=> s.transmit_shift_register ==
    {1'b0, $past(s.transmit_shift_register[8:1])})
    else $error("data not shifted lsb first");

  // shift empty status trails the busy state by one cycle
  AST_SHIFT_EMPTY: assert property ( // R13
    s.shift_busy |=> !s.shift_register_empty_status)
    else $error("shift empty status not cleared after load");

  // a holding write always clears the buffer empty flag
  AST_FLAG_CLEAR: assert property ( // R11
    holding_write |=> !s.tx_buffer_empty_flag ##1
    (s.holding_full || s.shift_busy))
    else $error("buffer empty flag not cleared by write");

  // interrupt follows flag and enable
  AST_IRQ_GATE: assert property ( // R12
    ##1 s.irq == $past(s.tx_buffer_empty_flag &&
    s.tx_buffer_interrupt_enable))
    else $error("interrupt not gated by enable");

  // disable aborts and returns the transmitter to idle, not busy
  AST_ABORT: assert property ( // R18
    !active |=> s.tx_state == async_tx_pkg::TX_IDLE
    && !s.shift_busy)
    else $error("transmitter not reset on disable");

  // divisor write restarts the timer at the new value
  AST_BAUD_RESTART: assert property ( // R21
    divisor_write |=> s.baud_count == s.baud_divisor)
    else $error("baud timer not restarted");

  // sleep freezes the sequence
  AST_SLEEP_HOLD: assert property ( // R7
    sleep_mode && active && !divisor_write |=> $stable(s.tx_state)
    && $stable(s.tick_count) && $stable(s.baud_count))
    else $error("activity during sleep");

  // buffer data moves at once into an empty shift register
  AST_IMMEDIATE_LOAD: assert property ( // R17
    s.tx_state == async_tx_pkg::TX_IDLE && active && s.holding_full
    && !sleep_mode && !holding_write |=> s.shift_busy
    && !s.holding_full ##1 s.tx_buffer_empty_flag)
    else $error("buffer not transferred at once");

endmodule // async_serial_transmitter
`default_nettype wire

// *** verilog/async_tx_pkg.sv ***
// constants, register map and state codes of the serial transmitter
// assumes a single 50 MHz clock and an AXI4-Lite register port
`default_nettype none
package async_tx_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_DIVISOR = 5'h04;
  localparam logic [4:0] OFS_HOLDING = 5'h08;
  localparam logic [4:0] OFS_FLAG = 5'h0c;
  localparam logic [4:0] OFS_ENABLE = 5'h10;
  localparam int MAP_BITS = 5;
  // control register fields
  localparam int BIT_NINE_SEL = 6;
  localparam int BIT_TX_EN = 5;
  localparam int BIT_CLOCKED = 4;
  localparam int BIT_HIGH_SPEED = 2;
  localparam int BIT_SHIFT_EMPTY = 1;
  localparam int BIT_NINTH = 0;
  // flag and enable register field
  localparam int BIT_BUF_EMPTY = 4;
  // reset values
  localparam logic RST_SHIFT_EMPTY = 1'b1;
  localparam logic [7:0] RST_DIVISOR = 8'h00;
  // ticks per bit, minus one
  localparam logic [5:0] LAST_TICK_HIGH = 6'h0f;
  localparam logic [5:0] LAST_TICK_LOW = 6'h3f;
  // data bits per frame
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // transmitter states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_WAIT = 3'b001,
    TX_START = 3'b010,
    TX_DATA = 3'b011,
    TX_STOP = 3'b100
  } tx_state_t;
endpackage
`default_nettype wire
